// file: por_gate_cfg.svh
// timing and reset constants for the power-on reset output gate
`ifndef POR_GATE_CFG_SVH
`define POR_GATE_CFG_SVH
`define POR_TO_WIDTH     16
`define POR_TO_DEFAULT   16'h0100
`define POR_TO_MIN       16'h0001
`endif

// file: por_gate_pkg.sv
// types for the power-on reset output gate
package por_gate_pkg;
    `include "por_gate_cfg.svh"
    typedef enum logic [1:0] {
        st_por,
        st_timeout,
        st_standby,
        st_active
    } por_state_e;
    typedef struct packed {
        por_state_e                      state;
        logic [`POR_TO_WIDTH-1:0]        timer;
        logic [2:0]                      por_sync;
        logic [2:0]                      cs_sync;
        logic                            ind_oe;
        logic                            host_cs;
        logic                            out_allow;
        logic                            in_standby;
    } por_gate_s;
endpackage : por_gate_pkg

// file: power_on_reset_output_gate.sv
// power-on reset indication output and host transaction gating
//
// How it works
// [R1] the reset indication pin is pulled low while the internal power-on reset runs.
// [R2] after that reset ends the pin stays low until the timeout expires, then floats.
// [R3] the block enters standby in the same cycle the pin is released.
// [R4] while the pin is low chip select is ignored and no transaction passes.
// [R5] while the pin is low every other output enable is held off.
// [R6] nothing here is clocked by the serial clock, so it may stop at will.
// [R7] the host opens a transaction by taking chip select low and closes it by raising it.
// [R8] with chip select high the device sits in standby unless busy, outputs undriven.
// [R9] the timeout length is a settled configuration value counted by an internal timer.
`timescale 1ns/10ps
`include "por_gate_cfg.svh"
module power_on_reset_output_gate
    import por_gate_pkg::*;
(
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     nrst,
    // internal power-on reset and configuration
    input  wire logic                     por_busy,
    input  wire logic [`POR_TO_WIDTH-1:0] timeout_cfg,
    input  wire logic                     embedded_busy,
    // host pins
    input  wire logic                     cs_n_pin,
    input  wire logic                     por_indication_out_n_in,
    // core side request to drive data outputs
    input  wire logic                     core_out_req,
    // pins driven
    output logic                          por_indication_out_n_o,
    output logic                          por_indication_out_n_oe,
    // gated towards the core
    output logic                          host_cs_active,
    output logic                          data_out_enable,
    output logic                          standby
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    por_gate_s cur_ff;
    por_gate_s nxt_ff;
    logic      por_s;
    logic      cs_low_s;
    logic      por_low_s;

    // second and third stages must agree before a change counts
    assign por_s     = cur_ff.por_sync[2] & cur_ff.por_sync[1];
    assign por_low_s = ~cur_ff.por_sync[2] & ~cur_ff.por_sync[1];
    assign cs_low_s  = ~cur_ff.cs_sync[2] & ~cur_ff.cs_sync[1];

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [`POR_TO_WIDTH-1:0] to_len(
        input logic [`POR_TO_WIDTH-1:0] cfg
    );
        // a zero setting would wrap the timer round to its top value before the pin window expires
        to_len = (cfg < `POR_TO_MIN) ? `POR_TO_MIN : cfg;
    endfunction : to_len

    // pin held low in every state before standby
    function automatic logic pin_held(input por_state_e st);
        pin_held = (st == st_por) || (st == st_timeout);
    endfunction : pin_held

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_ff          = cur_ff;
        nxt_ff.por_sync = {cur_ff.por_sync[1:0], por_busy};
        nxt_ff.cs_sync  = {cur_ff.cs_sync[1:0], cs_n_pin};
        case (cur_ff.state)
            st_por: begin
                if (por_low_s) begin
                    nxt_ff.state = st_timeout;
                    nxt_ff.timer = to_len(timeout_cfg); // R9
                end
            end
            st_timeout: begin
                if (por_s) begin
                    nxt_ff.state = st_por;
                end else if (cur_ff.timer == `POR_TO_MIN) begin
                    nxt_ff.state = st_standby; // R2 R3
                end else begin
                    nxt_ff.timer = cur_ff.timer - `POR_TO_MIN; // R9
                end
            end
            st_standby: begin
                if (por_s) begin
                    nxt_ff.state = st_por;
                end else if (cs_low_s) begin
                    nxt_ff.state = st_active; // R7
                end
            end
            st_active: begin
                if (por_s) begin
                    nxt_ff.state = st_por;
                end else if (cur_ff.cs_sync[2] && cur_ff.cs_sync[1]) begin
                    nxt_ff.state = st_standby; // R8
                end
            end
            default: begin
                nxt_ff.state = st_por;
            end
        endcase
        // R1 R2 pin low in any state before standby
        nxt_ff.ind_oe     = pin_held(nxt_ff.state); // R1 R2
        nxt_ff.host_cs    = (nxt_ff.state == st_active); // R4
        nxt_ff.out_allow  = (nxt_ff.state == st_active) && core_out_req; // R5 R8
        nxt_ff.in_standby = (nxt_ff.state == st_standby) && !embedded_busy; // R3 R8
    end

    // R6 only sys_clk is used; the serial clock never reaches this logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff.state      <= st_por;
            cur_ff.timer      <= `POR_TO_DEFAULT;
            cur_ff.por_sync   <= 3'h7;
            cur_ff.cs_sync    <= 3'h7;
            cur_ff.ind_oe     <= 1'b1;
            cur_ff.host_cs    <= 1'b0;
            cur_ff.out_allow  <= 1'b0;
            cur_ff.in_standby <= 1'b0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open drain: data is always low, only the enable moves
    assign por_indication_out_n_o  = 1'b0;
    assign por_indication_out_n_oe = cur_ff.ind_oe;
    assign host_cs_active          = cur_ff.host_cs;
    assign data_out_enable         = cur_ff.out_allow;
    assign standby                 = cur_ff.in_standby;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_timeout_end;
        (cur_ff.state == st_timeout) && !por_s && (cur_ff.timer == `POR_TO_MIN);
    endsequence

    sequence s_por_done;
        (cur_ff.state == st_por) && por_low_s;
    endsequence

    // a select that lands while the pin is held must not reach the core in the next cycle
    sequence s_select_in_reset;
        por_indication_out_n_oe && cs_low_s;
    endsequence

    // pin and timeout
    a_pin_low_por: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
        (cur_ff.state == st_por) |-> por_indication_out_n_oe)
        else $error("reset pin released during power-on reset");
    a_od_low_data: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
        !por_indication_out_n_o)
        else $error("open drain pin data not low");
    a_por_return: assert property (@(posedge sys_clk) disable iff (!nrst) // R1
        por_s |=> (cur_ff.state == st_por) && por_indication_out_n_oe)
        else $error("reset pin not pulled low on power-on reset");
    a_release_timer: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
        $fell(por_indication_out_n_oe) |-> $past(cur_ff.timer) == `POR_TO_MIN)
        else $error("reset pin released before timeout");
    a_por_exit: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
        s_por_done |=> (cur_ff.state == st_timeout))
        else $error("timeout not started after power-on reset");
    a_timeout_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // R2
        pin_held(cur_ff.state) |-> por_indication_out_n_oe)
        else $error("reset pin released during timeout");
    a_standby_release: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
        s_timeout_end |=> !por_indication_out_n_oe && (cur_ff.state == st_standby))
        else $error("standby not entered at pin release");
    a_standby_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R3
        s_timeout_end |=> (standby == !$past(embedded_busy)))
        else $error("standby output wrong at pin release");

    // host side gating
    a_cs_blocked: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
        por_indication_out_n_oe |-> !host_cs_active)
        else $error("chip select accepted while reset pin low");
    a_select_ignored: assert property (@(posedge sys_clk) disable iff (!nrst) // R4
        s_select_in_reset |=> !host_cs_active)
        else $error("select during reset hold reached the core");
    a_outputs_off: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
        por_indication_out_n_oe |-> !data_out_enable)
        else $error("output driven while reset pin low");
    a_dout_request: assert property (@(posedge sys_clk) disable iff (!nrst) // R5
        !core_out_req |=> !data_out_enable)
        else $error("output enabled without core request");
    a_no_serial_clk: assert property (@(posedge sys_clk) disable iff (!nrst) // R6
        (cur_ff.state == st_standby) && cs_low_s && !por_s |=> host_cs_active)
        else $error("transaction start missed without serial clock");
    a_cs_high_idle: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        (cur_ff.cs_sync[2] && cur_ff.cs_sync[1]) |=> !host_cs_active && !data_out_enable)
        else $error("outputs active with chip select high");
    a_cs_release: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        (cur_ff.state == st_active) && !por_s && cur_ff.cs_sync[2] && cur_ff.cs_sync[1]
        |=> (cur_ff.state == st_standby))
        else $error("standby not entered after deselect");
    a_busy_standby: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        embedded_busy |=> !standby)
        else $error("standby shown while embedded operation runs");
    a_standby_cs: assert property (@(posedge sys_clk) disable iff (!nrst) // R8
        standby |-> !host_cs_active && !data_out_enable)
        else $error("standby shown while selected");

    // timeout counter
    a_timer_load: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        (cur_ff.state == st_por) ##1 (cur_ff.state == st_timeout)
        |-> cur_ff.timer == to_len($past(timeout_cfg)))
        else $error("timeout not loaded from configuration");
    a_timer_dec: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        (cur_ff.state == st_timeout) && !por_s && (cur_ff.timer != `POR_TO_MIN)
        |=> cur_ff.timer == $past(cur_ff.timer) - `POR_TO_MIN)
        else $error("timeout counter stalled");
    a_timer_floor: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        (cur_ff.state == st_timeout) |-> (cur_ff.timer >= `POR_TO_MIN))
        else $error("timeout counter below its floor");

endmodule : power_on_reset_output_gate

// file: host_reset_model.sv
// host and board side of the reset indication line and chip select
`timescale 1ns/10ps
module host_reset_model (
    // request from the bench
    input  wire logic cs_req,
    // open-drain reset indication from the device
    input  wire logic ind_o,
    input  wire logic ind_oe,
    // pins seen by the device
    output logic      cs_n,
    output logic      ind_line
);
    // select is low only for the length of a transaction
    assign cs_n     = ~cs_req;
    // external pull-up wins whenever the device lets go
    assign ind_line = ind_oe ? ind_o : 1'b1;
endmodule : host_reset_model

// file: test_power_on_reset_output_gate.sv
// self-checking bench for the power-on reset output gate
`timescale 1ns/10ps
`include "por_gate_cfg.svh"
module test_power_on_reset_output_gate;
    import por_gate_pkg::*;
    logic                     sys_clk = 1'b0, nrst = 1'b0, por_busy = 1'b1;
    logic                     embedded_busy = 1'b0, cs_req = 1'b0, core_out_req = 1'b1;
    logic [`POR_TO_WIDTH-1:0] timeout_cfg = 16'h0004;
    logic                     cs_n, ind_line, ind_o, ind_oe, cs_act, dout_en, standby;
    int                       n_errors = 0, n_checks = 0, n;
    always #10 sys_clk = ~sys_clk;
    host_reset_model i_host_reset_model (.cs_req(cs_req), .ind_o(ind_o), .ind_oe(ind_oe),
        .cs_n(cs_n), .ind_line(ind_line));
    power_on_reset_output_gate i_power_on_reset_output_gate (.sys_clk(sys_clk), .nrst(nrst),
        .por_busy(por_busy), .timeout_cfg(timeout_cfg), .embedded_busy(embedded_busy),
        .cs_n_pin(cs_n), .por_indication_out_n_in(ind_line), .core_out_req(core_out_req),
        .por_indication_out_n_o(ind_o), .por_indication_out_n_oe(ind_oe),
        .host_cs_active(cs_act), .data_out_enable(dout_en), .standby(standby));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task end_of_test;
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task chk(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
            n_errors++;
        end
    endtask : chk
    task chk_num(input string name, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
            n_errors++;
        end
    endtask : chk_num
    task clk(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : clk
    // bounded wait; running out of cycles ends the run
    task automatic wait_bit(ref logic s, input logic exp, input int lim, output int cnt);
        #1;
        cnt = 0;
        while (s !== exp && cnt < lim) begin
            clk(1);
            cnt++;
        end
        if (s !== exp) begin
            chk("wait bound", exp, s);
            end_of_test();
        end
    endtask : wait_bit
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_power_up(input logic [`POR_TO_WIDTH-1:0] cfg, input int nexp);
        @(posedge sys_clk) cs_req <= 1'b1;
        clk(8);
        chk("oe during por", 1'b1, ind_oe);
        chk("line during por", 1'b0, ind_line);
        chk("cs during por", 1'b0, cs_act);
        chk("dout during por", 1'b0, dout_en);
        @(posedge sys_clk) begin
            timeout_cfg <= cfg;
            por_busy    <= 1'b0;
            cs_req      <= 1'b0;
        end
        #1;
        chk("oe early", 1'b1, ind_oe);
        wait_bit(ind_oe, 1'b0, 60, n);
        chk_num("timeout length", nexp + 4, n);
        chk("line released", 1'b1, ind_line);
        chk("standby at release", 1'b1, standby);
    endtask : t_power_up
    task t_cs;
        @(posedge sys_clk) cs_req <= 1'b1;
        wait_bit(cs_act, 1'b1, 8, n);
        chk_num("select delay", 4, n);
        chk("standby when selected", 1'b0, standby);
        chk("dout when selected", 1'b1, dout_en);
        @(posedge sys_clk) core_out_req <= 1'b0;
        clk(2);
        chk("dout without request", 1'b0, dout_en);
        chk("cs without request", 1'b1, cs_act);
        @(posedge sys_clk) core_out_req <= 1'b1;
        @(posedge sys_clk) cs_req <= 1'b0;
        clk(6);
        chk("cs released", 1'b0, cs_act);
        chk("dout deselected", 1'b0, dout_en);
        chk("standby deselected", 1'b1, standby);
        @(posedge sys_clk) embedded_busy <= 1'b1;
        clk(3);
        chk("standby while busy", 1'b0, standby);
        @(posedge sys_clk) embedded_busy <= 1'b0;
        clk(3);
        chk("standby after busy", 1'b1, standby);
    endtask : t_cs
    task t_repor;
        @(posedge sys_clk) por_busy <= 1'b1;
        wait_bit(ind_oe, 1'b1, 10, n);
        chk_num("repor delay", 4, n);
        chk("line in repor", 1'b0, ind_line);
        chk("standby in repor", 1'b0, standby);
    endtask : t_repor
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        clk(2);
        t_power_up(16'h0004, 4);
        t_cs;
        t_repor;
        t_power_up(16'h0000, 1);
        end_of_test();
    end
endmodule : test_power_on_reset_output_gate
